//--- logic/rtcpi_pkg.sv
// Constants, register map and hour-encoding helper for the RTC control block
package rtcpi_pkg;

    localparam logic [3:0] RTCPI_ADDR_SECONDS = 4'h0;
    localparam logic [3:0] RTCPI_ADDR_CTRL1 = 4'he;
    localparam logic [3:0] RTCPI_ADDR_CTRL2 = 4'hf;
    localparam logic [7:0] RTCPI_CTRL1_RESET = 8'h00;
    localparam logic [7:0] RTCPI_READ_UNMAPPED = 8'h00;

    // Control register one bit positions
    localparam int unsigned C1_WEEKLY_EN = 7;
    localparam int unsigned C1_DAILY_EN = 6;
    localparam int unsigned C1_HOUR24 = 5;
    localparam int unsigned C1_GATE_B_N = 4;
    localparam int unsigned C1_TEST = 3;
    localparam int unsigned C1_SEL_LSB = 0;
    localparam int unsigned C1_SEL_W = 3;

    // Control register two bit positions
    localparam int unsigned C2_VDSL = 7;
    localparam int unsigned C2_VDET = 6;
    localparam int unsigned C2_SCRATCH1 = 5;
    localparam int unsigned C2_HALT = 4;
    localparam int unsigned C2_GATE_A_N = 3;
    localparam int unsigned C2_PERIODIC_IRQ_FLAG = 2;
    localparam int unsigned C2_WEEKLY_ALARM_FLAG = 1;
    localparam int unsigned C2_DAILY_ALARM_FLAG = 0;

    // Time base
    localparam int unsigned XTAL_HZ = 32768;
    localparam int unsigned SUBSEC_W = 15;
    localparam int unsigned PULSE_LEAD_US = 92;
    localparam logic [SUBSEC_W-1:0] PULSE_LEAD_TICKS =
        SUBSEC_W'((PULSE_LEAD_US * XTAL_HZ + 500000) / 1000000);
    localparam logic [15:0] STEP_HOLD = 16'h0000;
    localparam logic [15:0] STEP_NORMAL = 16'h0001;
    localparam logic [15:0] STEP_SKIP = 16'h0002;

    // Hour encodings
    localparam logic [5:0] HOUR_AM12 = 6'h12;
    localparam logic [5:0] HOUR_PM12 = 6'h32;
    localparam logic [5:0] HOUR_PM_BIT = 6'h20;
    localparam logic [4:0] HOUR_NOON = 5'h0c;
    localparam logic [4:0] BCD_RADIX = 5'h0a;

    typedef enum logic [2:0] {
        PS_OFF = 3'b000,
        PS_LOW = 3'b001,
        PS_2HZ = 3'b010,
        PS_1HZ = 3'b011,
        PS_SEC = 3'b100,
        PS_MIN = 3'b101,
        PS_HOUR = 3'b110,
        PS_MONTH = 3'b111
    } rtcpi_sel_t;

    // 24-hour BCD hour to 12-hour BCD with PM flag in bit 5
    function automatic logic [5:0] rtcpi_hour12(input logic [5:0] bcd24);
        logic [4:0] h;
        logic [4:0] m;
        logic [5:0] b;
        h = 5'(bcd24[5:4]) * BCD_RADIX + 5'(bcd24[3:0]);
        m = (h > HOUR_NOON) ? 5'(h - HOUR_NOON) : h;
        b = (m >= BCD_RADIX) ? {2'b01, 4'(m - BCD_RADIX)} : {2'b00, m[3:0]};
        if (h == 5'h00) begin
            return HOUR_AM12;
        end
        if (h == HOUR_NOON) begin
            return HOUR_PM12;
        end
        return (h > HOUR_NOON) ? (b | HOUR_PM_BIT) : b;
    endfunction

endpackage

//--- logic/rtcpi_xfer.sv
// Toggle-handshake word crossing between two clock domains
`timescale 1ns/1ps
module rtcpi_xfer #(
    parameter int W = 8
) (
    input wire logic src_clk,
    input wire logic src_rst_b,
    input wire logic src_load,
    input wire logic [W-1:0] src_data,
    output logic src_busy,
    input wire logic dst_clk,
    input wire logic dst_rst_b,
    output logic dst_valid,
    output logic [W-1:0] dst_data
);
    typedef struct packed {
        logic [W-1:0] data;
        logic req;
        logic ack_s1;
        logic ack_s2;
        logic busy;
    } rtcpi_src_t;

    typedef struct packed {
        logic req_s1;
        logic req_s2;
        logic req_s3;
        logic valid;
        logic [W-1:0] data;
    } rtcpi_dst_t;

    rtcpi_src_t s_q;
    rtcpi_src_t s_d;
    rtcpi_dst_t t_q;
    rtcpi_dst_t t_d;
    logic start;

    // Source word is held until the acknowledge toggle returns, so the
    // destination may sample it without a per-bit synchroniser
    always_comb begin
        s_d = s_q;
        start = src_load & ~s_q.busy;
        s_d.ack_s1 = t_q.req_s3;
        s_d.ack_s2 = s_q.ack_s1;
        if (start) begin
            s_d.data = src_data;
            s_d.req = ~s_q.req;
        end
        s_d.busy = start | (s_q.busy & (s_q.ack_s2 != s_q.req));
    end

    always_ff @(posedge src_clk) begin
        if (!src_rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    always_comb begin
        t_d = t_q;
        t_d.req_s1 = s_q.req;
        t_d.req_s2 = t_q.req_s1;
        t_d.req_s3 = t_q.req_s2;
        t_d.valid = t_q.req_s2 ^ t_q.req_s3;
        if (t_q.req_s2 ^ t_q.req_s3) begin
            t_d.data = s_q.data;
        end
    end

    always_ff @(posedge dst_clk) begin
        if (!dst_rst_b) begin
            t_q <= '0;
        end else begin
            t_q <= t_d;
        end
    end

    assign src_busy = s_q.busy;
    assign dst_valid = t_q.valid;
    assign dst_data = t_q.data;
endmodule

//--- logic/rtcpi_control.sv
// RTC control register one, clock output gating and periodic interrupt
// How it works
// - Oscillation-halt flag setting clears all of control register one.
// - Weekly and daily alarm enable bits switch their alarm circuits on.
// - Hour-format bit picks 12-hour form at 0, 24-hour at 1.
// - 12-hour form: midnight 12, noon 32, bit 5 marks PM.
// - Slow clock runs unless both gating bits are 1, then held high.
// - Non-gateable variant keeps D4 as plain spare read-write bit.
// - Test bit selects factory test mode; software keeps it 0.
// - Select 000 releases interrupt; 001 holds it low.
// - Select 010 gives 2 Hz, 011 gives 1 Hz, half duty, second aligned.
// - Level mode fires each second, minute, hour or month start.
// - Pulse falling edge leads seconds increment by about 92 microseconds.
// - Writing seconds clears sub-second divider, pulling output low.
// - Level-mode falling edge coincides with seconds increment.
// - Oscillation adjustment may stretch or shrink a cycle slightly.
// - Periodic flag reads 1 while low; writing 0 releases level mode.
// - Alarm flags read 0 when disabled, set on match, cleared by 0.
`timescale 1ns/1ps
module rtcpi_control #(
    parameter bit CLKOUT_GATEABLE = 1'b1
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic LINK_CLK,
    input wire logic LINK_RST_B,
    input wire logic LINK_WR,
    input wire logic [3:0] LINK_ADDR,
    input wire logic [7:0] LINK_WDATA,
    output logic [7:0] LINK_RDATA,
    output logic LINK_BUSY,
    input wire logic OSC_32K,
    input wire logic OSC_HALT,
    input wire logic ROLL_TO_MIN,
    input wire logic ROLL_TO_HOUR,
    input wire logic ROLL_TO_MONTH,
    input wire logic WEEKLY_MATCH,
    input wire logic DAILY_MATCH,
    input wire logic ADJ_HOLD,
    input wire logic ADJ_SKIP,
    input wire logic [5:0] HOUR24_BCD,
    output logic SEC_TICK,
    output logic [5:0] HOUR_FORM_BCD,
    output logic HOUR_24_MODE,
    output logic WEEKLY_ALARM_ENABLE,
    output logic DAILY_ALARM_ENABLE,
    output logic TEST_MODE,
    output logic OSC_HALT_FLAG,
    output logic IRQ_OUT_N_O,
    output logic IRQ_OUT_N_OE_N,
    output logic SLOW_CLOCK_OUT_O,
    output logic SLOW_CLOCK_OUT_OE_N
);
    import rtcpi_pkg::*;

    typedef struct packed {
        logic osc_s1;
        logic osc_s2;
        logic osc_s3;
        logic halt_s1;
        logic halt_s2;
        logic [7:0] ctrl1;
        logic vdsl;
        logic scratch1;
        logic gate_a_n;
        logic halt_flag;
        logic weekly_alarm_flag;
        logic daily_alarm_flag;
        logic lvl;
        logic per_low;
        logic [SUBSEC_W-1:0] pre;
        logic hold_pend;
        logic skip_pend;
        logic sec_tick;
        logic [5:0] hour_out;
        logic irq_oe_n;
        logic clk_oe_n;
        logic pin_lo;
    } rtcpi_core_t;

    typedef struct packed {
        logic [7:0] rdata;
    } rtcpi_link_t;

    rtcpi_core_t q;
    rtcpi_core_t d;
    rtcpi_link_t lq;
    rtcpi_link_t ld;

    logic wr_valid;
    logic [11:0] wr_word;
    logic rb_busy;
    logic rb_valid;
    logic [15:0] rb_word;
    logic [15:0] rb_snap;

    // Link writes cross as one address-and-data word
    rtcpi_xfer #(.W(12)) u_wr_xfer (
        .src_clk(LINK_CLK),
        .src_rst_b(LINK_RST_B),
        .src_load(LINK_WR),
        .src_data({LINK_ADDR, LINK_WDATA}),
        .src_busy(LINK_BUSY),
        .dst_clk(CLK),
        .dst_rst_b(RST_B),
        .dst_valid(wr_valid),
        .dst_data(wr_word)
    );

    // Register image is refreshed toward the link as fast as the handshake allows
    rtcpi_xfer #(.W(16)) u_rb_xfer (
        .src_clk(CLK),
        .src_rst_b(RST_B),
        .src_load(~rb_busy),
        .src_data(rb_snap),
        .src_busy(rb_busy),
        .dst_clk(LINK_CLK),
        .dst_rst_b(LINK_RST_B),
        .dst_valid(rb_valid),
        .dst_data(rb_word)
    );

    always_comb begin
        rb_snap = {q.ctrl1,
                   q.vdsl, 1'b0, q.scratch1, q.halt_flag, q.gate_a_n,
                   q.per_low,
                   q.weekly_alarm_flag & q.ctrl1[C1_WEEKLY_EN],
                   q.daily_alarm_flag & q.ctrl1[C1_DAILY_EN]};
    end

    logic tick32;
    logic sec_write;
    logic c1_write;
    logic c2_write;
    logic carry;
    logic level_hit;
    logic is_level;
    logic gated;
    logic [15:0] sum;
    logic [15:0] step;
    logic [SUBSEC_W-1:0] phase;
    logic [3:0] wa;
    logic [7:0] wd;
    rtcpi_sel_t sel;

    always_comb begin
        d = q;
        wa = wr_word[11:8];
        wd = wr_word[7:0];
        sec_write = wr_valid & (wa == RTCPI_ADDR_SECONDS);
        c1_write = wr_valid & (wa == RTCPI_ADDR_CTRL1);
        c2_write = wr_valid & (wa == RTCPI_ADDR_CTRL2);

        // The crystal edge is taken from the second and third stages; halt uses only the second
        d.osc_s1 = OSC_32K;
        d.osc_s2 = q.osc_s1;
        d.osc_s3 = q.osc_s2;
        d.halt_s1 = OSC_HALT;
        d.halt_s2 = q.halt_s1;
        tick32 = q.osc_s2 & ~q.osc_s3;

        // Adjustment requests wait for the next crystal tick
        step = q.hold_pend ? STEP_HOLD : (q.skip_pend ? STEP_SKIP : STEP_NORMAL);
        sum = 16'(q.pre) + step;
        carry = 1'b0;
        if (tick32) begin
            d.pre = sum[SUBSEC_W-1:0];
            carry = sum[SUBSEC_W];
            d.hold_pend = 1'b0;
            d.skip_pend = 1'b0;
        end
        if (sec_write) begin
            d.pre = '0;
            carry = 1'b0;
            d.hold_pend = 1'b0;
            d.skip_pend = 1'b0;
        end
        // Requests are set after the tick clear so one landing on a tick is kept
        if (ADJ_HOLD) begin
            d.hold_pend = 1'b1;
        end
        if (ADJ_SKIP) begin
            d.skip_pend = 1'b1;
        end
        d.sec_tick = carry;

        if (c1_write) begin
            d.ctrl1 = wd;
        end
        sel = rtcpi_sel_t'(d.ctrl1[C1_SEL_LSB +: C1_SEL_W]);
        is_level = d.ctrl1[C1_SEL_LSB + C1_SEL_W - 1];

        case (sel)
            PS_SEC: level_hit = 1'b1;
            PS_MIN: level_hit = ROLL_TO_MIN;
            PS_HOUR: level_hit = ROLL_TO_HOUR;
            PS_MONTH: level_hit = ROLL_TO_MONTH;
            default: level_hit = 1'b0;
        endcase

        if (c2_write) begin
            d.vdsl = wd[C2_VDSL];
            d.scratch1 = wd[C2_SCRATCH1];
            d.gate_a_n = wd[C2_GATE_A_N];
            if (!wd[C2_HALT]) begin
                d.halt_flag = 1'b0;
            end
            if (!wd[C2_PERIODIC_IRQ_FLAG] && is_level) begin
                d.lvl = 1'b0;
            end
            if (!wd[C2_WEEKLY_ALARM_FLAG]) begin
                d.weekly_alarm_flag = 1'b0;
            end
            if (!wd[C2_DAILY_ALARM_FLAG]) begin
                d.daily_alarm_flag = 1'b0;
            end
        end

        // Sets are applied after clears so a same-cycle event is kept
        if (carry && level_hit) begin
            d.lvl = 1'b1;
        end
        if (!is_level) begin
            d.lvl = 1'b0;
        end
        if (WEEKLY_MATCH && d.ctrl1[C1_WEEKLY_EN]) begin
            d.weekly_alarm_flag = 1'b1;
        end
        if (DAILY_MATCH && d.ctrl1[C1_DAILY_EN]) begin
            d.daily_alarm_flag = 1'b1;
        end
        // Disabled alarms drop stale matches so re-enabling starts clean
        if (!d.ctrl1[C1_WEEKLY_EN]) begin
            d.weekly_alarm_flag = 1'b0;
        end
        if (!d.ctrl1[C1_DAILY_EN]) begin
            d.daily_alarm_flag = 1'b0;
        end

        // Halt detect dominates any write in the same cycle
        if (q.halt_s2) begin
            d.halt_flag = 1'b1;
            d.ctrl1 = RTCPI_CTRL1_RESET;
            d.vdsl = 1'b0;
            d.scratch1 = 1'b0;
            d.gate_a_n = 1'b0;
            d.weekly_alarm_flag = 1'b0;
            d.daily_alarm_flag = 1'b0;
            d.lvl = 1'b0;
        end

        sel = rtcpi_sel_t'(d.ctrl1[C1_SEL_LSB +: C1_SEL_W]);
        phase = d.pre + PULSE_LEAD_TICKS;
        case (sel)
            PS_OFF: d.per_low = 1'b0;
            PS_LOW: d.per_low = 1'b1;
            PS_2HZ: d.per_low = ~phase[SUBSEC_W-2];
            PS_1HZ: d.per_low = ~phase[SUBSEC_W-1];
            default: d.per_low = d.lvl;
        endcase

        d.irq_oe_n = ~(d.per_low
                       | (d.weekly_alarm_flag & d.ctrl1[C1_WEEKLY_EN])
                       | (d.daily_alarm_flag & d.ctrl1[C1_DAILY_EN]));

        gated = CLKOUT_GATEABLE & d.ctrl1[C1_GATE_B_N] & d.gate_a_n;
        // Released (high) while gated or while the crystal phase is high
        d.clk_oe_n = gated | q.osc_s2;

        d.hour_out = d.ctrl1[C1_HOUR24] ? HOUR24_BCD : rtcpi_hour12(HOUR24_BCD);
        d.pin_lo = 1'b0;
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            q <= '0;
            q.halt_flag <= 1'b1;
            q.irq_oe_n <= 1'b1;
            q.clk_oe_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Reads return the last image crossed in; other addresses read as zero
    always_comb begin
        ld = lq;
        case (LINK_ADDR)
            RTCPI_ADDR_CTRL1: ld.rdata = rb_word[15:8];
            RTCPI_ADDR_CTRL2: ld.rdata = rb_word[7:0];
            default: ld.rdata = RTCPI_READ_UNMAPPED;
        endcase
    end

    always_ff @(posedge LINK_CLK) begin
        if (!LINK_RST_B) begin
            lq <= '0;
        end else begin
            lq <= ld;
        end
    end

    assign LINK_RDATA = lq.rdata;
    assign SEC_TICK = q.sec_tick;
    assign HOUR_FORM_BCD = q.hour_out;
    assign HOUR_24_MODE = q.ctrl1[C1_HOUR24];
    assign WEEKLY_ALARM_ENABLE = q.ctrl1[C1_WEEKLY_EN];
    assign DAILY_ALARM_ENABLE = q.ctrl1[C1_DAILY_EN];
    assign TEST_MODE = q.ctrl1[C1_TEST];
    assign OSC_HALT_FLAG = q.halt_flag;
    assign IRQ_OUT_N_O = q.pin_lo;
    assign IRQ_OUT_N_OE_N = q.irq_oe_n;
    assign SLOW_CLOCK_OUT_O = q.pin_lo;
    assign SLOW_CLOCK_OUT_OE_N = q.clk_oe_n;
endmodule

//--- tb/rtcpi_assertions.sv
// Port-level checks on the RTC control block
`timescale 1ns/1ps
module rtcpi_assertions (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic OSC_HALT,
    input wire logic WEEKLY_MATCH,
    input wire logic DAILY_MATCH,
    input wire logic [5:0] HOUR24_BCD,
    input wire logic SEC_TICK,
    input wire logic [5:0] HOUR_FORM_BCD,
    input wire logic HOUR_24_MODE,
    input wire logic WEEKLY_ALARM_ENABLE,
    input wire logic DAILY_ALARM_ENABLE,
    input wire logic TEST_MODE,
    input wire logic OSC_HALT_FLAG,
    input wire logic IRQ_OUT_N_O,
    input wire logic IRQ_OUT_N_OE_N,
    input wire logic SLOW_CLOCK_OUT_O
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    // Synchroniser latency allows a few cycles before the clear shows
    AST_HALT_CLR: assert property (OSC_HALT [*5] |-> OSC_HALT_FLAG && !HOUR_24_MODE
        && !WEEKLY_ALARM_ENABLE && !DAILY_ALARM_ENABLE && !TEST_MODE)
        else $error("control bits kept during halt");
    AST_HALT_IRQ: assert property (OSC_HALT [*8] |-> IRQ_OUT_N_OE_N)
        else $error("interrupt driven during halt");
    AST_WEEKLY: assert property (WEEKLY_MATCH && WEEKLY_ALARM_ENABLE |=> !IRQ_OUT_N_OE_N)
        else $error("weekly match did not interrupt");
    AST_DAILY: assert property (DAILY_MATCH && DAILY_ALARM_ENABLE |=> !IRQ_OUT_N_OE_N)
        else $error("daily match did not interrupt");
    AST_HOUR24: assert property (HOUR_24_MODE |-> HOUR_FORM_BCD == $past(HOUR24_BCD))
        else $error("24-hour form altered");
    AST_AM12: assert property ((!HOUR_24_MODE && HOUR24_BCD == 6'h00) [*3]
        |-> HOUR_FORM_BCD == 6'h12)
        else $error("midnight code wrong");
    AST_PM12: assert property ((!HOUR_24_MODE && HOUR24_BCD == 6'h12) [*3]
        |-> HOUR_FORM_BCD == 6'h32)
        else $error("noon code wrong");
    AST_SEC_ONE: assert property (SEC_TICK |=> !SEC_TICK)
        else $error("seconds tick longer than one cycle");
    AST_OD_LOW: assert property (!IRQ_OUT_N_O && !SLOW_CLOCK_OUT_O)
        else $error("open-drain pin drives high");
endmodule

//--- tb/rtcpi_host.sv
// Host model issuing register writes and reads over the link
`timescale 1ns/1ps
module rtcpi_host (
    input wire logic link_clk,
    input wire logic link_busy,
    input wire logic [7:0] link_rdata,
    output logic link_wr,
    output logic [3:0] link_addr,
    output logic [7:0] link_wdata
);
    import rtcpi_pkg::*;
    initial begin
        link_wr = 1'b0;
        link_addr = 4'h0;
        link_wdata = 8'h00;
    end
    task automatic write(input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        if (a == RTCPI_ADDR_CTRL1) begin
            d[C1_TEST] = 1'b0;
        end
        @(posedge link_clk);
        while (link_busy && n < 50) begin
            @(posedge link_clk);
            n++;
        end
        link_wr <= 1'b1;
        link_addr <= a;
        link_wdata <= d;
        @(posedge link_clk);
        link_wr <= 1'b0;
        // Idle data shows the inverse so a stale value cannot pass
        link_wdata <= ~d;
        n = 0;
        do begin
            @(posedge link_clk);
            n++;
        end while (link_busy && n < 50);
        repeat (20) @(posedge link_clk);
    endtask
    // Readback image lags by a handshake round, so wait before sampling
    task automatic read(input logic [3:0] a, output logic [7:0] d);
        repeat (25) @(posedge link_clk);
        link_addr <= a;
        repeat (3) @(posedge link_clk);
        d = link_rdata;
    endtask
endmodule

//--- tb/rtcpi_control_tb.sv
// Self-checking testbench for the RTC control block
`timescale 1ns/1ps
module rtcpi_control_tb;
    import rtcpi_pkg::*;
    logic clk, rst_b, lclk, lrst_b, lwr, busy, osc, halt, wm, dm, skip, tick, rmin;
    logic h24, wen, den, tmode, hflag, irq_o, irq_oe_n, sck_o, sck_oe_n;
    logic [3:0] laddr;
    logic [7:0] lwdata, lrdata;
    logic [5:0] hin, hout;
    int bad_count, num_checks;

    rtcpi_control rtcpi_control_inst (.CLK(clk), .RST_B(rst_b), .LINK_CLK(lclk),
        .LINK_RST_B(lrst_b), .LINK_WR(lwr), .LINK_ADDR(laddr), .LINK_WDATA(lwdata),
        .LINK_RDATA(lrdata), .LINK_BUSY(busy), .OSC_32K(osc), .OSC_HALT(halt),
        .ROLL_TO_MIN(rmin), .ROLL_TO_HOUR(1'b0), .ROLL_TO_MONTH(1'b0), .WEEKLY_MATCH(wm),
        .DAILY_MATCH(dm), .ADJ_HOLD(1'b0), .ADJ_SKIP(skip), .HOUR24_BCD(hin),
        .SEC_TICK(tick), .HOUR_FORM_BCD(hout), .HOUR_24_MODE(h24),
        .WEEKLY_ALARM_ENABLE(wen), .DAILY_ALARM_ENABLE(den), .TEST_MODE(tmode),
        .OSC_HALT_FLAG(hflag), .IRQ_OUT_N_O(irq_o), .IRQ_OUT_N_OE_N(irq_oe_n),
        .SLOW_CLOCK_OUT_O(sck_o), .SLOW_CLOCK_OUT_OE_N(sck_oe_n));
    rtcpi_host rtcpi_host_inst (.link_clk(lclk), .link_busy(busy), .link_rdata(lrdata),
        .link_wr(lwr), .link_addr(laddr), .link_wdata(lwdata));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        lclk = 1'b0;
        #13;
        forever #40 lclk = ~lclk;
    end
    // Fast crystal keeps a full second within the run
    always @(posedge clk) osc <= ~osc;

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        rtcpi_host_inst.write(a, d);
        @(posedge clk);
        #1;
    endtask
    task automatic reg_is(input string what, input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rtcpi_host_inst.read(a, v);
        check(what, v, exp);
        @(posedge clk);
        #1;
    endtask
    task automatic irq_is(input logic exp);
        check("irq", {7'h0, irq_oe_n}, {7'h0, exp});
    endtask
    task automatic clk_runs(input logic exp);
        logic p;
        int n;
        n = 0;
        p = sck_oe_n;
        repeat (40) begin
            @(posedge clk);
            #1;
            if (sck_oe_n !== p) n++;
            p = sck_oe_n;
        end
        check("clkout", {6'h0, n > 0, (n == 0) && (sck_oe_n !== 1'b1)}, {6'h0, exp, 1'b0});
    endtask
    task automatic pulse();
        @(posedge clk);
        wm <= 1'b1;
        dm <= 1'b1;
        @(posedge clk);
        wm <= 1'b0;
        dm <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic t_reset();
        reg_is("ctrl1", RTCPI_ADDR_CTRL1, RTCPI_CTRL1_RESET);
        reg_is("ctrl2", RTCPI_ADDR_CTRL2, 8'h10);
        irq_is(1'b1);
        clk_runs(1'b1);
        wr(RTCPI_ADDR_CTRL2, 8'h00);
    endtask
    task automatic t_hour();
        logic [5:0] hi [5] = '{6'h00, 6'h12, 6'h13, 6'h11, 6'h23};
        logic [5:0] ex [5] = '{6'h12, 6'h32, 6'h21, 6'h11, 6'h31};
        wr(RTCPI_ADDR_CTRL1, 8'h00);
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            hin <= hi[i];
            repeat (3) @(posedge clk);
            #1;
            check("hour12", {2'b00, hout}, {2'b00, ex[i]});
        end
        wr(RTCPI_ADDR_CTRL1, 8'h20);
        repeat (3) @(posedge clk);
        #1;
        check("hour24", {h24, 1'b0, hout}, 8'ha3);
    endtask
    task automatic t_gate();
        wr(RTCPI_ADDR_CTRL1, 8'h10);
        clk_runs(1'b1);
        wr(RTCPI_ADDR_CTRL2, 8'h08);
        clk_runs(1'b0);
        wr(RTCPI_ADDR_CTRL1, 8'h00);
        clk_runs(1'b1);
        wr(RTCPI_ADDR_CTRL2, 8'h00);
    endtask
    task automatic t_alarm();
        wr(RTCPI_ADDR_CTRL1, 8'h80);
        pulse();
        irq_is(1'b0);
        reg_is("flags", RTCPI_ADDR_CTRL2, 8'h02);
        wr(RTCPI_ADDR_CTRL2, 8'h00);
        irq_is(1'b1);
        wr(RTCPI_ADDR_CTRL1, 8'h40);
        pulse();
        irq_is(1'b0);
        reg_is("flags", RTCPI_ADDR_CTRL2, 8'h01);
        wr(RTCPI_ADDR_CTRL1, 8'h00);
        pulse();
        irq_is(1'b1);
        reg_is("flags", RTCPI_ADDR_CTRL2, 8'h00);
    endtask
    task automatic t_sel();
        wr(RTCPI_ADDR_CTRL1, 8'h01);
        irq_is(1'b0);
        reg_is("flags", RTCPI_ADDR_CTRL2, 8'h04);
        wr(RTCPI_ADDR_CTRL1, 8'h00);
        irq_is(1'b1);
    endtask
    // About 12000 ticks into the second: 2 Hz sits in its high half, 1 Hz still low
    task automatic t_pulse();
        wr(RTCPI_ADDR_CTRL1, 8'h02);
        wr(RTCPI_ADDR_SECONDS, 8'h00);
        irq_is(1'b0);
        repeat (24000) @(posedge clk);
        #1;
        irq_is(1'b1);
        wr(RTCPI_ADDR_CTRL1, 8'h03);
        irq_is(1'b0);
    endtask
    // Skip requests halve the wait; the minute source is held active throughout
    task automatic t_level(input logic [7:0] sel);
        logic p;
        int n;
        wr(RTCPI_ADDR_CTRL1, sel);
        @(posedge clk);
        skip <= 1'b1;
        rmin <= 1'b1;
        #1;
        n = 0;
        p = irq_oe_n;
        while (tick !== 1'b1 && n < 40000) begin
            p = irq_oe_n;
            @(posedge clk);
            #1;
            n++;
        end
        check("tick", {7'h0, tick}, 8'h01);
        check("fall", {6'h0, p, irq_oe_n}, 8'h02);
        @(posedge clk);
        skip <= 1'b0;
        rmin <= 1'b0;
        #1;
        reg_is("flags", RTCPI_ADDR_CTRL2, 8'h04);
        wr(RTCPI_ADDR_CTRL2, 8'h00);
        irq_is(1'b1);
        wr(RTCPI_ADDR_CTRL1, 8'h00);
    endtask
    task automatic t_halt();
        wr(RTCPI_ADDR_CTRL1, 8'hf7);
        wr(RTCPI_ADDR_CTRL2, 8'h08);
        @(posedge clk);
        halt <= 1'b1;
        repeat (10) @(posedge clk);
        #1;
        check("halted", {h24, wen, den, irq_oe_n, hflag, tmode, 2'h0}, 8'h18);
        @(posedge clk);
        halt <= 1'b0;
        reg_is("ctrl1", RTCPI_ADDR_CTRL1, 8'h00);
        reg_is("ctrl2", RTCPI_ADDR_CTRL2, 8'h10);
        clk_runs(1'b1);
    endtask

    initial begin
        // Three part-seconds of crystal time plus register traffic need about 80000
        repeat (90000) @(posedge clk);
        bad_count++;
        results();
    end
    initial begin
        {rst_b, lrst_b, osc, halt, wm, dm, skip, rmin} = 8'h00;
        hin = 6'h00;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        lrst_b <= 1'b1;
        repeat (25) @(posedge lclk);
        t_reset();
        t_hour();
        t_gate();
        t_alarm();
        t_sel();
        t_pulse();
        t_level(8'h04);
        t_level(8'h05);
        t_halt();
        results();
    end
endmodule

bind rtcpi_control rtcpi_assertions rtcpi_assertions_inst (.CLK(CLK), .RST_B(RST_B),
    .OSC_HALT(OSC_HALT), .WEEKLY_MATCH(WEEKLY_MATCH), .DAILY_MATCH(DAILY_MATCH),
    .HOUR24_BCD(HOUR24_BCD), .SEC_TICK(SEC_TICK), .HOUR_FORM_BCD(HOUR_FORM_BCD),
    .HOUR_24_MODE(HOUR_24_MODE), .WEEKLY_ALARM_ENABLE(WEEKLY_ALARM_ENABLE),
    .DAILY_ALARM_ENABLE(DAILY_ALARM_ENABLE), .TEST_MODE(TEST_MODE),
    .OSC_HALT_FLAG(OSC_HALT_FLAG), .IRQ_OUT_N_O(IRQ_OUT_N_O),
    .IRQ_OUT_N_OE_N(IRQ_OUT_N_OE_N), .SLOW_CLOCK_OUT_O(SLOW_CLOCK_OUT_O));
